// File: hdl/wdco_exec.sv
// execution unit for watchdog clear, decrement, invert, decrement-skip
// assumes the register file returns reg_rdata for reg_addr in the same
// cycle and that instr_valid marks one issued instruction per clock
`include "wdco_cfg.svh"
module wdco_exec (
  input wire logic clock,
  input wire logic resetn,
  input wire logic instr_valid,
  input wire logic [13:0] instr,
  output logic [6:0] reg_addr,
  input wire logic [7:0] reg_rdata,
  output logic reg_we,
  output logic [7:0] reg_wdata,
  output logic acc_we,
  output logic [7:0] acc_wdata,
  output logic [7:0] result_q,
  output logic zero_flag_we,
  output logic zero_flag_q,
  output logic watchdog_counter_clr,
  output logic [7:0] watchdog_counter_q,
  output logic [7:0] prescaler_q,
  output logic timeout_flag_q,
  output logic sleep_flag_q,
  output logic discard_fetched,
  output logic nop_cycle_q,
  output logic busy
);
  import wdco_pkg::*;

  // ****************************************
  // decode and operands
  // ****************************************
  wdco_op_t op; // decoded class
  wdco_state_t state_q; // run or skip slot
  logic issue; // instruction really executes
  logic dest_reg; // one selects file register
  logic [7:0] res_d; // alu result
  logic res_zero; // alu result all zeros

  wdco_decode u_decode (
    .instr(instr),
    .op(op)
  );

  // an instruction landing in the skip slot is thrown away
  assign issue = instr_valid && (state_q == WDCO_RUN);
  assign dest_reg = instr[`WDCO_DEST_BIT];
  assign reg_addr = instr[6:0];

  // ****************************************
  // alu
  // ****************************************
  // subtract wraps 00 to ff, no borrow kept since no carry is touched
  always_comb begin
    case (op)
      WDCO_DEC: res_d = reg_rdata - `WDCO_ONE_BYTE;
      WDCO_DSKIP: res_d = reg_rdata - `WDCO_ONE_BYTE;
      WDCO_INV: res_d = ~reg_rdata;
      default: res_d = `WDCO_ZERO_BYTE;
    endcase
  end
  assign res_zero = (res_d == `WDCO_ZERO_BYTE);

  // ****************************************
  // writeback strobes
  // ****************************************
  logic file_op; // one of the three file ops
  assign file_op = issue && (op == WDCO_DEC || op == WDCO_INV || op == WDCO_DSKIP);
  // destination select; data comes from the alu, strobes are combinational
  assign reg_we = file_op && dest_reg;
  assign acc_we = file_op && !dest_reg;
  assign reg_wdata = res_d;
  assign acc_wdata = res_d;
  // decrement-skip leaves every flag alone
  assign zero_flag_we = issue && (op == WDCO_DEC || op == WDCO_INV);
  assign watchdog_counter_clr = issue && (op == WDCO_CLRWD);
  // skip request: fetched word must be dropped by the core
  assign discard_fetched = issue && (op == WDCO_DSKIP) && res_zero;
  assign busy = (state_q == WDCO_SKIP);

  // ****************************************
  // result register
  // ****************************************
  // last file-op result, for visibility
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      result_q <= `WDCO_ZERO_BYTE;
    end else if (file_op) begin
      result_q <= res_d;
    end
  end

  // ****************************************
  // zero flag
  // ****************************************
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      zero_flag_q <= `WDCO_ZFLAG_RST;
    end else if (zero_flag_we) begin
      zero_flag_q <= res_zero;
    end
  end

  // ****************************************
  // watchdog counter and prescaler
  // ****************************************
  // the timer itself lives elsewhere; these mirror the cleared state
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      watchdog_counter_q <= `WDCO_ZERO_BYTE;
      prescaler_q <= `WDCO_ZERO_BYTE;
    end else if (watchdog_counter_clr) begin
      watchdog_counter_q <= `WDCO_ZERO_BYTE;
      prescaler_q <= `WDCO_ZERO_BYTE;
    end
  end

  // ****************************************
  // status flags
  // ****************************************
  // reset value is 1 as after a power-on; only watchdog clear writes here
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      timeout_flag_q <= `WDCO_STATUS_RST;
      sleep_flag_q <= `WDCO_STATUS_RST;
    end else if (watchdog_counter_clr) begin
      timeout_flag_q <= 1'b1;
      sleep_flag_q <= 1'b1;
    end
  end

  // ****************************************
  // skip sequencer
  // ****************************************
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_q <= WDCO_RUN;
    end else begin
      case (state_q)
        WDCO_RUN: begin
          if (discard_fetched) begin
            state_q <= WDCO_SKIP;
          end
        end
        // the nop slot always lasts exactly one cycle
        WDCO_SKIP: state_q <= WDCO_RUN;
        default: state_q <= WDCO_RUN;
      endcase
    end
  end

  // marks the inserted no-operation cycle
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      nop_cycle_q <= 1'b0;
    end else begin
      nop_cycle_q <= discard_fetched;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  AST_WD_CLEAR: assert property (@(posedge clock) disable iff (!resetn)
    watchdog_counter_clr |=> (watchdog_counter_q == 8'h00 && prescaler_q == 8'h00))
    else $error("watchdog counter or prescaler not zero after clear");
  AST_FLAGS_SET: assert property (@(posedge clock) disable iff (!resetn)
    watchdog_counter_clr |=> (timeout_flag_q && sleep_flag_q))
    else $error("status flags not set by watchdog clear");
  AST_DEC_RES: assert property (@(posedge clock) disable iff (!resetn)
    (issue && op == WDCO_DEC) |-> (res_d == reg_rdata - 8'h01 && zero_flag_we))
    else $error("decrement result wrong");
  AST_INV_RES: assert property (@(posedge clock) disable iff (!resetn)
    (issue && op == WDCO_INV) |-> (res_d == ~reg_rdata))
    else $error("invert result wrong");
  AST_DEST: assert property (@(posedge clock) disable iff (!resetn)
    file_op |-> (reg_we == instr[7] && acc_we == !instr[7]))
    else $error("destination select wrong");
  AST_NOFLAG: assert property (@(posedge clock) disable iff (!resetn)
    (issue && op == WDCO_DSKIP) |=> $stable(zero_flag_q))
    else $error("decrement-skip changed zero flag");
  AST_DISCARD: assert property (@(posedge clock) disable iff (!resetn)
    discard_fetched |=> (!reg_we && !acc_we && !zero_flag_we && !watchdog_counter_clr))
    else $error("discarded instruction had an effect");
  AST_TWO_CYC: assert property (@(posedge clock) disable iff (!resetn)
    discard_fetched |=> busy ##1 !busy)
    else $error("skip slot not exactly one cycle");
  AST_EXACT_OPC: assert property (@(posedge clock) disable iff (!resetn)
    watchdog_counter_clr |-> (instr == 14'h0064))
    else $error("watchdog clear on partial opcode");
  AST_ZERO: assert property (@(posedge clock) disable iff (!resetn)
    zero_flag_we |=> (zero_flag_q == ($past(res_d) == 8'h00)))
    else $error("zero flag wrong");
  COV_SKIP: cover property (@(posedge clock) disable iff (!resetn) discard_fetched);
  COV_CLR: cover property (@(posedge clock) disable iff (!resetn) watchdog_counter_clr);
  COV_INV_Z: cover property (@(posedge clock) disable iff (!resetn)
    issue && op == WDCO_INV && res_zero);
  COV_DEC_REG: cover property (@(posedge clock) disable iff (!resetn)
    issue && op == WDCO_DEC && reg_we);

  // ****************************************
  // slot and sequencing checks
  // ****************************************
  // a word offered in the nop slot must leave every strobe low, or the
  // core would execute the instruction it was told to drop
  AST_SLOT_QUIET: assert property (@(posedge clock) disable iff (!resetn)
    busy |-> (!reg_we && !acc_we && !zero_flag_we && !watchdog_counter_clr && !discard_fetched))
    else $error("strobe raised in the nop slot");
  // nop marker and skip state must agree cycle for cycle
  AST_NOP_MARK: assert property (@(posedge clock) disable iff (!resetn)
    nop_cycle_q == busy)
    else $error("nop marker out of step with skip slot");
  // skip judged from the operand, not the alu zero detect, so a broken
  // detector cannot vouch for itself
  AST_SKIP_ON_ONE: assert property (@(posedge clock) disable iff (!resetn)
    (issue && op == WDCO_DSKIP) |-> (discard_fetched == (reg_rdata == 8'h01)))
    else $error("skip decision wrong for operand");
  AST_DSKIP_RES: assert property (@(posedge clock) disable iff (!resetn)
    (issue && op == WDCO_DSKIP) |-> (res_d == reg_rdata - 8'h01 && !zero_flag_we))
    else $error("decrement-skip result wrong or flag written");
  // the visible result register trails the file op by one edge
  AST_RES_REG: assert property (@(posedge clock) disable iff (!resetn)
    file_op |=> (result_q == $past(res_d)))
    else $error("result register missed a file op");
  COV_DSKIP_KEEP: cover property (@(posedge clock) disable iff (!resetn)
    issue && op == WDCO_DSKIP && !res_zero);
endmodule

// File: hdl/wdco_cfg.svh
// constants for the watchdog-clear and decrement execution block
// assumes one instruction issued per clock by the surrounding core
`ifndef WDCO_CFG_SVH
`define WDCO_CFG_SVH
// ****************************************
// instruction fields
// ****************************************
`define WDCO_OPC_CLRWD 14'h0064
`define WDCO_OPC_DEC 6'h03
`define WDCO_OPC_INV 6'h09
`define WDCO_OPC_DSKIP 6'h0b
`define WDCO_OP_HI 13
`define WDCO_OP_LO 8
`define WDCO_DEST_BIT 7
// ****************************************
// reset values and byte constants
// ****************************************
`define WDCO_ZERO_BYTE 8'h00
`define WDCO_ONE_BYTE 8'h01
`define WDCO_STATUS_RST 1'b1
`define WDCO_ZFLAG_RST 1'b0
`endif

// File: hdl/wdco_pkg.sv
// types for the watchdog-clear and decrement execution block
// assumes the cfg header is included alongside
package wdco_pkg;
  // decoded operation class
  typedef enum logic [2:0] {
    WDCO_NONE,
    WDCO_CLRWD,
    WDCO_DEC,
    WDCO_INV,
    WDCO_DSKIP
  } wdco_op_t;
  // execute pipeline state
  typedef enum logic {
    WDCO_RUN,
    WDCO_SKIP
  } wdco_state_t;
endpackage

// File: hdl/wdco_decode.sv
// combinational opcode decoder
// assumes a 14-bit instruction word from the fetch stage
`include "wdco_cfg.svh"
module wdco_decode (
  input wire logic [13:0] instr,
  output wdco_pkg::wdco_op_t op
);
  import wdco_pkg::*;
  // ****************************************
  // decode
  // ****************************************
  // the full 14 bits must match for watchdog clear
  always_comb begin
    if (instr == `WDCO_OPC_CLRWD) begin
      op = WDCO_CLRWD;
    end else begin
      case (instr[`WDCO_OP_HI:`WDCO_OP_LO])
        `WDCO_OPC_DEC: op = WDCO_DEC;
        `WDCO_OPC_INV: op = WDCO_INV;
        `WDCO_OPC_DSKIP: op = WDCO_DSKIP;
        default: op = WDCO_NONE;
      endcase
    end
  end
endmodule

// File: dv/wdco_exec_tb.sv
// self-checking bench for the watchdog-clear and decrement execution unit
// assumes the bench plays register file and fetch stage, one word a cycle
`include "wdco_cfg.svh"
module wdco_exec_tb;
  timeunit 1ns;
  timeprecision 100ps;
  // ****************************************
  // stimulus and observed signals
  // ****************************************
  logic clock, resetn, instr_valid; // bench-driven controls
  logic [13:0] instr; // issued word
  logic [7:0] reg_rdata; // register file answer
  logic [6:0] reg_addr;
  logic reg_we, acc_we, zero_flag_we, watchdog_counter_clr, discard_fetched;
  logic [7:0] reg_wdata, acc_wdata, result_q, watchdog_counter_q, prescaler_q;
  logic zero_flag_q, timeout_flag_q, sleep_flag_q, nop_cycle_q, busy;
  int mismatches = 0; // failed compares
  int compares = 0; // all compares
  logic zf = 1'b0; // expected zero flag
  wdco_exec u_wdco_exec (.clock(clock), .resetn(resetn), .instr_valid(instr_valid),
    .instr(instr), .reg_addr(reg_addr), .reg_rdata(reg_rdata), .reg_we(reg_we),
    .reg_wdata(reg_wdata), .acc_we(acc_we), .acc_wdata(acc_wdata), .result_q(result_q),
    .zero_flag_we(zero_flag_we), .zero_flag_q(zero_flag_q),
    .watchdog_counter_clr(watchdog_counter_clr), .watchdog_counter_q(watchdog_counter_q),
    .prescaler_q(prescaler_q), .timeout_flag_q(timeout_flag_q), .sleep_flag_q(sleep_flag_q),
    .discard_fetched(discard_fetched), .nop_cycle_q(nop_cycle_q), .busy(busy));
  // ****************************************
  // shared helpers
  // ****************************************
  // free-running core clock, 8 ns
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  // four-state compare, counted
  task chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // issue one word just after the edge, then let strobes settle
  task put(input logic [13:0] word, input logic [7:0] rd);
    @(posedge clock);
    #1;
    instr_valid = 1'b1;
    instr = word;
    reg_rdata = rd;
    #1;
  endtask
  // one cycle with nothing issued; registers from the last word are visible
  task idle;
    @(posedge clock);
    #1;
    instr_valid = 1'b0;
    #1;
  endtask
  // verdict, the single exit of the run
  task complete_run;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  // watchdog clear, then words one bit away that must not clear
  task t_clear;
    logic [13:0] near [3];
    near = '{14'h0065, 14'h0044, 14'h2064};
    put(`WDCO_OPC_CLRWD, 8'h00);
    chk("clr strobe", watchdog_counter_clr, 1);
    chk("clr zero we", zero_flag_we, 0);
    chk("clr writes", {reg_we, acc_we}, 0);
    idle;
    chk("counter", watchdog_counter_q, 0);
    chk("prescaler", prescaler_q, 0);
    chk("flags", {timeout_flag_q, sleep_flag_q}, 2'b11);
    chk("zero kept", zero_flag_q, zf);
    chk("single cycle", busy, 0);
    foreach (near[i]) begin
      put(near[i], 8'h00);
      chk("near clr", watchdog_counter_clr, 0);
      chk("near quiet", {reg_we, acc_we, zero_flag_we, discard_fetched}, 0);
    end
    idle;
    $display("test watchdog clear done");
  endtask
  // one file-register op; a zero skip result also probes the nop cycle
  task t_file(input logic [5:0] op, input logic d, input logic [7:0] rd);
    logic [7:0] exp;
    logic skip;
    logic [6:0] a;
    a = rd[6:0] ^ 7'h2a;
    exp = (op == `WDCO_OPC_INV) ? ~rd : rd - 8'h01;
    skip = (op == `WDCO_OPC_DSKIP) && (exp == 8'h00);
    put({op, d, a}, rd);
    chk("addr", reg_addr, a);
    chk("reg we", reg_we, d);
    chk("acc we", acc_we, !d);
    chk("result", d ? reg_wdata : acc_wdata, exp);
    chk("zero we", zero_flag_we, op != `WDCO_OPC_DSKIP);
    chk("discard", discard_fetched, skip);
    if (op != `WDCO_OPC_DSKIP) begin
      zf = (exp == 8'h00);
    end
    // the word fetched behind a skip must vanish
    if (skip) begin
      put({`WDCO_OPC_DEC, 1'b1, a}, 8'h40);
      chk("nop cycle", {busy, nop_cycle_q}, 2'b11);
      chk("dropped word", {reg_we, acc_we, zero_flag_we}, 0);
    end
    idle;
    chk("zero flag", zero_flag_q, zf);
    chk("result reg", result_q, exp);
    chk("busy after", {busy, nop_cycle_q}, 2'b00);
    $display("test file op %h done", op);
  endtask
  // reset dropped inside a nop slot, then a decrement right after release
  task t_reset_mid;
    put({`WDCO_OPC_DSKIP, 1'b1, 7'h11}, 8'h01);
    chk("mid discard", discard_fetched, 1);
    @(posedge clock);
    #1;
    chk("mid slot", busy, 1);
    instr_valid = 1'b0;
    resetn = 1'b0;
    #1;
    chk("mid busy", {busy, nop_cycle_q}, 2'b00);
    chk("mid flags", {timeout_flag_q, sleep_flag_q, zero_flag_q}, 3'b110);
    @(posedge clock);
    #1;
    resetn = 1'b1;
    zf = 1'b0;
    t_file(`WDCO_OPC_DEC, 1'b0, 8'h01);
    $display("test mid-run reset done");
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    resetn = 1'b0;
    instr_valid = 1'b0;
    instr = 14'h0000;
    reg_rdata = 8'h00;
    repeat (4) @(posedge clock);
    #1;
    resetn = 1'b1;
    chk("reset flags", {timeout_flag_q, sleep_flag_q, zero_flag_q}, 3'b110);
    chk("reset idle", {busy, nop_cycle_q, watchdog_counter_q}, 0);
    $display("test reset done");
    t_clear;
    t_file(`WDCO_OPC_DEC, 1'b0, 8'h01);
    t_file(`WDCO_OPC_DEC, 1'b1, 8'h00);
    t_file(`WDCO_OPC_INV, 1'b0, 8'h13);
    t_file(`WDCO_OPC_INV, 1'b1, 8'hff);
    t_file(`WDCO_OPC_DSKIP, 1'b1, 8'h05);
    t_file(`WDCO_OPC_DEC, 1'b1, 8'h05);
    t_file(`WDCO_OPC_DSKIP, 1'b1, 8'h01);
    t_file(`WDCO_OPC_DSKIP, 1'b0, 8'h01);
    t_file(`WDCO_OPC_DSKIP, 1'b0, 8'h00);
    t_reset_mid;
    t_clear;
    complete_run;
  end
  // hang guard, far beyond the planned run
  initial begin
    #100000;
    mismatches++;
    complete_run;
  end
endmodule
